/* File: shared/ssb_pkg.sv */
package ssb_pkg;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_VTHR = 8'h04;
  localparam logic [7:0] A_TOUT = 8'h08;
  localparam logic [7:0] A_DBIL = 8'h0C;
  localparam logic [7:0] A_OVTH = 8'h10;
  localparam logic [7:0] A_UVTH = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam logic [7:0] A_IRQS = 8'h1C;
  localparam logic [7:0] A_IRQM = 8'h20;
  localparam int CB_SWEN = 0;
  localparam int CB_BRKFN = 1;
  localparam int CB_BRKIMM = 2;
  localparam int CB_MODE = 4;
  localparam int CB_FCLR = 7;
  localparam int IRQ_W = 4;
  localparam int IB_STOP = 0;
  localparam int IB_BRAKE = 1;
  localparam int IB_OV = 2;
  localparam int IB_FAULT = 3;
  localparam logic [15:0] RST_VTHR = 16'h0040;
  localparam logic [15:0] RST_DBIL = 16'h0800;
  localparam logic [11:0] RST_OVTH = 12'hE00;
  localparam logic [11:0] RST_UVTH = 12'h200;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [23:0] CNT_MAX = 24'hFFFFFF;
  localparam int CLK_PERIOD_NS = 40;
  localparam int STOP_TIMEOUT_NS = 10_000_000;
  localparam int STOP_TIMEOUT_CYC = STOP_TIMEOUT_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {DM_COAST = 2'b00, DM_DBRAKE = 2'b01,
    DM_CTRL = 2'b10, DM_RSVD = 2'b11} ssb_mode_t;
  typedef enum logic [1:0] {FC_DISABLE = 2'b00, FC_DBRAKE = 2'b01,
    FC_CTRL = 2'b10, FC_RSVD = 2'b11} ssb_fcls_t;
  typedef enum logic [2:0] {ST_HOLD = 3'b000, ST_RUN = 3'b001,
    ST_DECEL = 3'b010, ST_DBRAKE = 3'b011, ST_COAST = 3'b100} ssb_st_t;
  typedef enum logic [1:0] {LED_GREEN = 2'b00, LED_WARN = 2'b01,
    LED_ORANGE = 2'b10, LED_FAULT = 2'b11} ssb_led_t;
  typedef struct packed {
    logic swen; logic brkfn; logic brkimm; ssb_mode_t mode;
    logic [15:0] vthr; logic [23:0] tout; logic [15:0] dbil;
    logic [11:0] ovth; logic [11:0] uvth; logic [IRQ_W-1:0] mask;
  } ssb_cfg_t;
  typedef struct packed {
    logic awr; logic [7:0] awa; logic wr; logic [31:0] wd;
    logic [3:0] ws; logic bv; logic [1:0] br;
    logic arr; logic rv; logic [31:0] rd; logic [1:0] rr;
  } ssb_axs_t;
  typedef struct packed {
    logic pwr; logic dbq; logic dz; logic dec; logic brk;
    logic act; ssb_led_t led; logic irq;
  } ssb_out_t;
endpackage

/* File: logic/ssb_top.sv */
`timescale 1ns/10ps
module ssb_top
  import ssb_pkg::*;
#(
  parameter logic [23:0] P_TIMEOUT_CYC = STOP_TIMEOUT_CYC[23:0]
)(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [7:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [7:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  input wire logic HW_ENABLE,
  input wire logic DI_STOP,
  input wire logic FAULT,
  input wire logic [1:0] FAULT_CLASS,
  input wire logic [15:0] VELOCITY,
  input wire logic [15:0] TERM_CURRENT,
  input wire logic [11:0] VBUS,
  output logic PWR_STAGE_EN,
  output logic DB_Q_SHORT,
  output logic D_ZERO_TARGET,
  output logic DECEL_REQ,
  output logic BRAKE_APPLY,
  output logic DRIVE_ACTIVE,
  output logic [1:0] LED_CODE,
  output logic IRQ
);

  ssb_axs_t bs_r, bs_nxt;
  ssb_cfg_t cfg_r, cfg_nxt;
  ssb_st_t st_r, st_nxt;
  ssb_out_t out_r, out_nxt;
  ssb_fcls_t fcls_r, fcls_nxt, cls;
  logic [23:0] cnt_r, cnt_nxt;
  logic flt_r, flt_nxt, ovf_r, ovf_nxt;
  logic [IRQ_W-1:0] irqs_r, irqs_nxt, ev;
  logic wr_fire, fclr, ov, flt_any, stop_cond, en_ok, cur_under;
  logic [31:0] wimg;

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        m[8*i +: 8] = d[8*i +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic [31:0] rdmux(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      A_CTRL: v = {26'h0, cfg_r.mode, 1'b0, cfg_r.brkimm,
        cfg_r.brkfn, cfg_r.swen};
      A_VTHR: v = {16'h0, cfg_r.vthr};
      A_TOUT: v = {8'h0, cfg_r.tout};
      A_DBIL: v = {16'h0, cfg_r.dbil};
      A_OVTH: v = {20'h0, cfg_r.ovth};
      A_UVTH: v = {20'h0, cfg_r.uvth};
      A_STAT: v = {24'h0, fcls_r, ovf_r, flt_r, out_r.brk, st_r};
      A_IRQS: v = {28'h0, irqs_r};
      A_IRQM: v = {28'h0, cfg_r.mask};
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  function automatic logic known(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= A_IRQM);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus slave and configuration.
  // A write lands once address and data are both held; the answer comes
  // one edge later, which keeps the register update and B in step.
  assign wr_fire = !bs_r.awr && !bs_r.wr && !bs_r.bv;
  assign wimg = merge(rdmux(bs_r.awa), bs_r.wd, bs_r.ws);

  always_comb
  begin
    bs_nxt = bs_r;
    cfg_nxt = cfg_r;
    if (AWVALID && bs_r.awr)
    begin
      bs_nxt.awr = 1'b0;
      bs_nxt.awa = AWADDR;
    end
    if (WVALID && bs_r.wr)
    begin
      bs_nxt.wr = 1'b0;
      bs_nxt.wd = WDATA;
      bs_nxt.ws = WSTRB;
    end
    if (wr_fire)
    begin
      bs_nxt.bv = 1'b1;
      bs_nxt.br = known(bs_r.awa) ? RESP_OKAY : RESP_SLVERR;
      case (bs_r.awa)
        A_CTRL:
        begin
          cfg_nxt.swen = wimg[CB_SWEN];
          cfg_nxt.brkfn = wimg[CB_BRKFN];
          cfg_nxt.brkimm = wimg[CB_BRKIMM];
          cfg_nxt.mode = ssb_mode_t'(wimg[CB_MODE +: 2]);
        end
        A_VTHR: cfg_nxt.vthr = wimg[15:0];
        A_TOUT: cfg_nxt.tout = wimg[23:0];
        A_DBIL: cfg_nxt.dbil = wimg[15:0];
        A_OVTH: cfg_nxt.ovth = wimg[11:0];
        A_UVTH: cfg_nxt.uvth = wimg[11:0];
        A_IRQM: cfg_nxt.mask = wimg[IRQ_W-1:0];
        default: cfg_nxt = cfg_r;
      endcase
    end
    if (bs_r.bv && BREADY)
    begin
      bs_nxt.bv = 1'b0;
      bs_nxt.awr = 1'b1;
      bs_nxt.wr = 1'b1;
    end
    if (ARVALID && bs_r.arr)
    begin
      bs_nxt.arr = 1'b0;
      bs_nxt.rv = 1'b1;
      bs_nxt.rd = rdmux(ARADDR);
      bs_nxt.rr = known(ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bs_r.rv && RREADY)
    begin
      bs_nxt.rv = 1'b0;
      bs_nxt.arr = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      bs_r <= '{awr: 1'b1, wr: 1'b1, arr: 1'b1, default: '0};
      cfg_r <= '{vthr: RST_VTHR, tout: P_TIMEOUT_CYC, dbil: RST_DBIL,
        ovth: RST_OVTH, uvth: RST_UVTH, mode: DM_CTRL, default: '0};
    end
    else
    begin
      bs_r <= bs_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stop and brake sequencer.
  assign fclr = wr_fire && bs_r.awa == A_CTRL && bs_r.ws[0]
    && bs_r.wd[CB_FCLR];
  assign ov = VBUS > cfg_r.ovth;
  assign flt_any = FAULT || ov || flt_r;
  assign stop_cond = (VELOCITY < cfg_r.vthr) || (cnt_r >= cfg_r.tout);
  assign en_ok = HW_ENABLE && cfg_r.swen && !flt_any && !DI_STOP;
  assign cur_under = TERM_CURRENT < cfg_r.dbil;

  always_comb
  begin
    st_nxt = st_r;
    // fault class, overvoltage forces a plain disable
    cls = ov ? FC_DISABLE : ((FAULT && !flt_r) ?
      ssb_fcls_t'(FAULT_CLASS) : fcls_r);
    case (st_r)
      ST_HOLD:
      begin
        if (en_ok)
        begin
          st_nxt = ST_RUN;
        end
      end
      ST_RUN, ST_DECEL, ST_DBRAKE:
      begin
        if (!HW_ENABLE)
        begin
          st_nxt = cfg_r.brkimm ? ST_HOLD : ST_COAST;
        end
        else if (flt_any)
        begin
          if (cfg_r.brkimm)
          begin
            st_nxt = ST_HOLD;
          end
          else if (cls == FC_DISABLE || cls == FC_RSVD)
          begin
            st_nxt = ST_COAST;
          end
          else if (st_r == ST_RUN)
          begin
            st_nxt = (cls == FC_DBRAKE) ? ST_DBRAKE : ST_DECEL;
          end
          else if (stop_cond)
          begin
            st_nxt = ST_HOLD;
          end
        end
        else if (st_r == ST_RUN)
        begin
          // stop input gives a controlled stop
          if (DI_STOP)
          begin
            st_nxt = ST_DECEL;
          end
          // software disable, mode picks the stop
          else if (!cfg_r.swen)
          begin
            case (cfg_r.mode)
              DM_DBRAKE: st_nxt = ST_DBRAKE;
              DM_CTRL: st_nxt = ST_DECEL;
              default: st_nxt = ST_COAST;
            endcase
          end
        end
        // end of stop on velocity or timeout
        else if (stop_cond)
        begin
          st_nxt = ST_HOLD;
        end
      end
      ST_COAST:
      begin
        if (stop_cond)
        begin
          st_nxt = ST_HOLD;
        end
      end
      default: st_nxt = ST_HOLD;
    endcase
    // stop timer restarts at every state entry
    if (st_nxt != st_r)
    begin
      cnt_nxt = 24'h0;
    end
    else
    begin
      cnt_nxt = (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 24'h1;
    end
    // A new fault wins over a clear in the same cycle.
    flt_nxt = (FAULT || ov) ? 1'b1 : (fclr ? 1'b0 : flt_r);
    ovf_nxt = ov ? 1'b1 : (fclr ? 1'b0 : ovf_r);
    fcls_nxt = flt_nxt ? cls : FC_DISABLE;
    ev = '0;
    ev[IB_STOP] = st_r == ST_RUN && st_nxt != ST_RUN;
    ev[IB_BRAKE] = st_nxt == ST_HOLD && st_r != ST_HOLD;
    ev[IB_OV] = ov && !ovf_r;
    ev[IB_FAULT] = flt_nxt && !flt_r;
    irqs_nxt = irqs_r;
    if (wr_fire && bs_r.awa == A_IRQS && bs_r.ws[0])
    begin
      irqs_nxt = irqs_r & ~bs_r.wd[IRQ_W-1:0];
    end
    irqs_nxt = irqs_nxt | ev;
    out_nxt.pwr = st_nxt == ST_RUN || st_nxt == ST_DECEL
      || st_nxt == ST_DBRAKE;
    out_nxt.act = st_nxt == ST_RUN || st_nxt == ST_DECEL;
    out_nxt.dec = st_nxt == ST_DECEL;
    // q shorted, d loop held at zero
    out_nxt.dz = st_nxt == ST_DBRAKE;
    // shorting pauses while current is at the cap
    out_nxt.dbq = st_nxt == ST_DBRAKE && cur_under;
    // brake applied while in hold, when the brake function is enabled
    out_nxt.brk = cfg_r.brkfn && st_nxt == ST_HOLD;
    if (flt_nxt)
    begin
      out_nxt.led = LED_FAULT;
    end
    else if (out_nxt.act)
    begin
      out_nxt.led = (VBUS < cfg_r.uvth) ? LED_WARN : LED_GREEN;
    end
    else
    begin
      out_nxt.led = LED_ORANGE;
    end
    out_nxt.irq = |(irqs_nxt & cfg_r.mask);
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      st_r <= ST_HOLD;
      cnt_r <= 24'h0;
      flt_r <= 1'b0;
      ovf_r <= 1'b0;
      fcls_r <= FC_DISABLE;
      irqs_r <= '0;
      out_r <= '{led: LED_ORANGE, default: '0};
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      flt_r <= flt_nxt;
      ovf_r <= ovf_nxt;
      fcls_r <= fcls_nxt;
      irqs_r <= irqs_nxt;
      out_r <= out_nxt;
    end
  end

  assign AWREADY = bs_r.awr;
  assign WREADY = bs_r.wr;
  assign BVALID = bs_r.bv;
  assign BRESP = bs_r.br;
  assign ARREADY = bs_r.arr;
  assign RVALID = bs_r.rv;
  assign RDATA = bs_r.rd;
  assign RRESP = bs_r.rr;
  assign PWR_STAGE_EN = out_r.pwr;
  assign DB_Q_SHORT = out_r.dbq;
  assign D_ZERO_TARGET = out_r.dz;
  assign DECEL_REQ = out_r.dec;
  assign BRAKE_APPLY = out_r.brk;
  assign DRIVE_ACTIVE = out_r.act;
  assign LED_CODE = out_r.led;
  assign IRQ = out_r.irq;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  chk_ov_shutdown: assert property (
    st_r == ST_RUN && ov |=> !PWR_STAGE_EN && flt_r && ovf_r)
    else $error("overvoltage did not shut the stage");
  chk_hw_disable: assert property (
    st_r != ST_HOLD && st_r != ST_COAST && !HW_ENABLE
    |=> !PWR_STAGE_EN && !DECEL_REQ)
    else $error("hardware disable left the stage on");
  chk_brake_now: assert property (
    st_r == ST_RUN && !HW_ENABLE && cfg_r.brkimm && cfg_r.brkfn
    |=> BRAKE_APPLY && st_r == ST_HOLD)
    else $error("immediate brake not applied");
  chk_dz_target: assert property (
    D_ZERO_TARGET |-> st_r == ST_DBRAKE && PWR_STAGE_EN)
    else $error("d target zero outside dynamic brake");
  chk_db_cap: assert property (
    DB_Q_SHORT |-> $past(cur_under) && D_ZERO_TARGET)
    else $error("short kept above current cap");
  chk_mode_decel: assert property (
    st_r == ST_RUN && HW_ENABLE && !flt_any && !DI_STOP
    && !cfg_r.swen && cfg_r.mode == DM_CTRL
    |=> DECEL_REQ ##0 PWR_STAGE_EN)
    else $error("mode two did not decelerate");
  chk_mode_dbrake: assert property (
    st_r == ST_RUN && HW_ENABLE && !flt_any && !DI_STOP
    && !cfg_r.swen && cfg_r.mode == DM_DBRAKE |=> D_ZERO_TARGET)
    else $error("mode one did not enter dynamic brake");
  chk_stop_input: assert property (
    st_r == ST_RUN && HW_ENABLE && !flt_any && DI_STOP
    |=> DECEL_REQ && DRIVE_ACTIVE)
    else $error("stop input did not decelerate");
  chk_stop_timer: assert property (
    st_r == ST_COAST && cnt_r >= cfg_r.tout |=> st_r == ST_HOLD)
    else $error("stop timeout did not end the stop");
  chk_brake_hold: assert property (
    $fell(DRIVE_ACTIVE) ##1 st_r == ST_HOLD && $past(cfg_r.brkfn)
    |-> BRAKE_APPLY)
    else $error("brake missing after drive inactive");
  chk_led_fault: assert property (
    flt_r |-> LED_CODE == LED_FAULT)
    else $error("fault not shown on led");

  cov_dbrake: cover property (st_r == ST_RUN ##1 st_r == ST_DBRAKE);
  cov_decel_hold: cover property (DECEL_REQ ##1 st_r == ST_HOLD);
  cov_coast_hold: cover property (st_r == ST_COAST ##1 BRAKE_APPLY);
  cov_irq: cover property ($rose(IRQ));

endmodule

/* File: testbench/ssb_motor_model.sv */
`timescale 1ns/10ps
// Motor, holding brake and supply as the drive sees them at its pins.
module ssb_motor_model
  import ssb_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PWR_STAGE_EN,
  input wire logic DECEL_REQ,
  input wire logic D_ZERO_TARGET,
  input wire logic BRAKE_APPLY,
  input wire logic [15:0] SPD_SET,
  input wire logic [15:0] RATE,
  input wire logic [15:0] CUR_SET,
  input wire logic [11:0] VBUS_SET,
  output logic [15:0] VELOCITY,
  output logic [15:0] TERM_CURRENT,
  output logic [11:0] VBUS
);
  logic [15:0] vel_r;
  logic [15:0] vel_nxt;

  // A free shaft slows by RATE each cycle, so a zero RATE never stops.
  always_comb
  begin
    vel_nxt = (vel_r > RATE) ? vel_r - RATE : 16'h0000;
    if (BRAKE_APPLY)
      vel_nxt = 16'h0000;
    else if (PWR_STAGE_EN && !DECEL_REQ && !D_ZERO_TARGET)
      vel_nxt = SPD_SET;
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      vel_r <= 16'h0000;
    else
      vel_r <= vel_nxt;
  end

  assign VELOCITY = vel_r;
  assign TERM_CURRENT = PWR_STAGE_EN ? CUR_SET : 16'h0000;
  assign VBUS = VBUS_SET;
endmodule

/* File: testbench/ssb_top_test.sv */
`timescale 1ns/10ps
module ssb_top_test
  import ssb_pkg::*;
;
  localparam logic [23:0] TOC = 24'h000014;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic BREADY = 1'b0, RREADY = 1'b0;
  logic AWVALID = 1'b0, WVALID = 1'b0, ARVALID = 1'b0;
  logic HW_ENABLE = 1'b1, DI_STOP = 1'b0, FAULT = 1'b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h00000000;
  logic [3:0] WSTRB = 4'hF;
  logic [1:0] FAULT_CLASS = 2'h0;
  logic [15:0] spd = 16'h0100, rate = 16'h0010, cur = 16'h0100;
  logic [11:0] vb = 12'h300;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  logic PWR_STAGE_EN, DB_Q_SHORT, D_ZERO_TARGET, DECEL_REQ;
  logic BRAKE_APPLY, DRIVE_ACTIVE;
  logic [1:0] BRESP, RRESP, LED_CODE;
  logic [31:0] RDATA;
  logic [15:0] VELOCITY, TERM_CURRENT;
  logic [11:0] VBUS;
  logic [6:0] outs;
  logic [3:0] mexp [4] = '{4'h0, 4'h7, 4'h9, 4'h0};
  int n_mismatch = 0;
  int cmp_count = 0;
  int n = 0;

  assign outs = {IRQ, DRIVE_ACTIVE, BRAKE_APPLY, DECEL_REQ, D_ZERO_TARGET,
    DB_Q_SHORT, PWR_STAGE_EN};
  initial forever #20 CLOCK = ~CLOCK;

  ssb_top #(.P_TIMEOUT_CYC(TOC)) dut_u (
    .CLOCK(CLOCK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA),
    .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .HW_ENABLE(HW_ENABLE), .DI_STOP(DI_STOP), .FAULT(FAULT),
    .FAULT_CLASS(FAULT_CLASS), .VELOCITY(VELOCITY),
    .TERM_CURRENT(TERM_CURRENT), .VBUS(VBUS), .PWR_STAGE_EN(PWR_STAGE_EN),
    .DB_Q_SHORT(DB_Q_SHORT), .D_ZERO_TARGET(D_ZERO_TARGET),
    .DECEL_REQ(DECEL_REQ), .BRAKE_APPLY(BRAKE_APPLY),
    .DRIVE_ACTIVE(DRIVE_ACTIVE), .LED_CODE(LED_CODE), .IRQ(IRQ)
  );
  ssb_motor_model motor_u (
    .CLOCK(CLOCK), .RST(RST), .PWR_STAGE_EN(PWR_STAGE_EN),
    .DECEL_REQ(DECEL_REQ), .D_ZERO_TARGET(D_ZERO_TARGET),
    .BRAKE_APPLY(BRAKE_APPLY), .SPD_SET(spd), .RATE(rate), .CUR_SET(cur),
    .VBUS_SET(vb), .VELOCITY(VELOCITY), .TERM_CURRENT(TERM_CURRENT),
    .VBUS(VBUS)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic hang();
    n_mismatch++;
    report_and_stop();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The leading edge keeps a ready from being dropped and raised at once.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    @(posedge CLOCK);
    n = 0;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do
    begin
      @(posedge CLOCK);
      n++;
      if (AWREADY === 1'b1)
        AWVALID <= 1'b0;
      if (WREADY === 1'b1)
        WVALID <= 1'b0;
    end while (BVALID !== 1'b1 && n < 60);
    if (BVALID !== 1'b1)
      hang();
    BREADY <= 1'b0;
    chk({30'h0, BRESP}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er);
    @(posedge CLOCK);
    n = 0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do
    begin
      @(posedge CLOCK);
      n++;
      if (ARREADY === 1'b1)
        ARVALID <= 1'b0;
    end while (RVALID !== 1'b1 && n < 60);
    if (RVALID !== 1'b1)
      hang();
    RREADY <= 1'b0;
    chk(RDATA, e);
    chk({30'h0, RRESP}, {30'h0, er});
  endtask

  task automatic wb(input int i, input logic v, input int lim);
    n = 0;
    while (outs[i] !== v && n < lim)
    begin
      @(posedge CLOCK);
      n++;
    end
    if (outs[i] !== v)
      hang();
  endtask

  task automatic go(input logic [7:0] c);
    wr(A_CTRL, {24'h0, c | 8'h01}, RESP_OKAY);
    wb(5, 1'b1, 20);
  endtask

  task automatic stp(input logic [7:0] c);
    wr(A_CTRL, {24'h0, c}, RESP_OKAY);
    repeat (2) @(posedge CLOCK);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    chk({30'h0, LED_CODE}, 32'(LED_ORANGE)); // Safe bus.
    rd(A_CTRL, 32'h20, RESP_OKAY);
    rd(A_VTHR, 32'(RST_VTHR), RESP_OKAY);
    rd(A_DBIL, 32'(RST_DBIL), RESP_OKAY);
    rd(A_OVTH, 32'(RST_OVTH), RESP_OKAY);
    rd(A_UVTH, 32'(RST_UVTH), RESP_OKAY);
    rd(A_STAT, 32'h0, RESP_OKAY);
    WSTRB <= 4'h1;
    wr(A_TOUT, 32'h00FFFF14, RESP_OKAY);
    WSTRB <= 4'hF;
    rd(A_TOUT, 32'(TOC), RESP_OKAY);
    rd(8'h24, 32'h0, RESP_SLVERR);
    rd(8'h06, 32'h0, RESP_SLVERR);
    wr(8'h24, 32'hFFFFFFFF, RESP_SLVERR);
    for (int m = 0; m < 4; m++)
    begin
      go({2'h0, m[1:0], 4'h2});
      stp({2'h0, m[1:0], 4'h2}); // Software stop.
      chk({28'h0, outs[3:0]}, {28'h0, mexp[m]}); // Mode reaction.
      wb(4, 1'b1, 40); // Brake follows.
      chk({31'h0, n < int'(TOC)}, 32'h1); // Early on speed.
      chk({31'h0, outs[0]}, 32'h0); // Stage off.
      wr(A_IRQS, 32'hF, RESP_OKAY);
    end
    rate <= 16'h0000;
    go(8'h22);
    stp(8'h22);
    wb(4, 1'b1, 40);
    chk({31'h0, n >= int'(TOC) - 3 && n <= int'(TOC) + 2}, 32'h1); // Late.
    rd(A_IRQS, 32'h3, RESP_OKAY);
    wr(A_IRQM, 32'h2, RESP_OKAY);
    wb(6, 1'b1, 4);
    wr(A_IRQS, 32'h2, RESP_OKAY);
    wb(6, 1'b0, 4);
    rd(A_IRQS, 32'h1, RESP_OKAY);
    wr(A_IRQS, 32'h1, RESP_OKAY);
    rate <= 16'h0010;
    cur <= 16'h0800;
    go(8'h12);
    stp(8'h12);
    chk({29'h0, outs[2:0]}, 32'h5); // Short lifted at limit.
    cur <= 16'h07FF;
    repeat (2) @(posedge CLOCK);
    chk({29'h0, outs[2:0]}, 32'h7); // Short with d target zero.
    wb(4, 1'b1, 40);
    go(8'h26);
    HW_ENABLE <= 1'b0;
    repeat (2) @(posedge CLOCK);
    chk({27'h0, outs[4:0]}, 32'h10); // Brake at once.
    wr(A_CTRL, 32'h23, RESP_OKAY);
    repeat (4) @(posedge CLOCK);
    chk({31'h0, outs[5]}, 32'h0); // No restart.
    stp(8'h22);
    HW_ENABLE <= 1'b1;
    go(8'h22);
    HW_ENABLE <= 1'b0;
    repeat (2) @(posedge CLOCK);
    chk({27'h0, outs[4:0]}, 32'h0); // No decel phase.
    wb(4, 1'b1, 40); // Brake follows.
    stp(8'h22);
    HW_ENABLE <= 1'b1;
    go(8'h22);
    DI_STOP <= 1'b1;
    repeat (2) @(posedge CLOCK);
    chk({28'h0, outs[3:0]}, 32'h9); // Controlled stop.
    wb(4, 1'b1, 40); // Brake after stop.
    // Drop the software enable first, or releasing the stop input restarts.
    stp(8'h22);
    DI_STOP <= 1'b0;
    for (int c = 0; c < 3; c++)
    begin
      go(8'h22);
      FAULT_CLASS <= c[1:0];
      FAULT <= 1'b1;
      repeat (2) @(posedge CLOCK);
      chk({28'h0, outs[3:0]}, {28'h0, mexp[c]}); // Class reaction.
      chk({30'h0, LED_CODE}, 32'(LED_FAULT)); // Fault colour.
      wb(4, 1'b1, 40);
      FAULT <= 1'b0;
      wr(A_CTRL, 32'hA2, RESP_OKAY);
    end
    go(8'h22);
    vb <= 12'hE00;
    repeat (3) @(posedge CLOCK);
    chk({31'h0, outs[0]}, 32'h1); // At threshold still on.
    vb <= 12'hE01;
    repeat (2) @(posedge CLOCK);
    chk({28'h0, outs[3:0]}, 32'h0); // Coasting.
    chk({30'h0, LED_CODE}, 32'(LED_FAULT)); // Fault raised.
    vb <= 12'h300;
    wb(4, 1'b1, 40);
    wr(A_CTRL, 32'hA2, RESP_OKAY);
    repeat (2) @(posedge CLOCK);
    chk({30'h0, LED_CODE}, 32'(LED_ORANGE)); // Safe bus.
    go(8'h22);
    vb <= 12'h1FF;
    repeat (2) @(posedge CLOCK);
    chk({30'h0, LED_CODE}, 32'(LED_WARN)); // Warning colour.
    vb <= 12'h200;
    repeat (2) @(posedge CLOCK);
    chk({30'h0, LED_CODE}, 32'(LED_GREEN)); // Running colour.
    stp(8'h22);
    wb(4, 1'b1, 40);
    report_and_stop();
  end
endmodule
